// ### logic/card_window_regs.svh
`ifndef CARD_WINDOW_REGS_SVH
`define CARD_WINDOW_REGS_SVH
`define WIN_EN_OFFSET 12'h806
`define IO_CTRL_OFFSET 12'h807
`define WIN_EN_RESET 8'h00
`define IO_CTRL_RESET 8'h00
`define WIN_EN_WRITE_MASK 8'hDF
`define IO1_EN_BIT 7
`define IO0_EN_BIT 6
`define RESERVED_BIT 5
`define IO1_WAIT_BIT 7
`define IO1_SHORT_BIT 6
`define IO1_AUTO_BIT 5
`define IO1_WIDTH_BIT 4
`define IO0_WAIT_BIT 3
`define IO0_SHORT_BIT 2
`define IO0_AUTO_BIT 1
`define IO0_WIDTH_BIT 0
`define IO_FIELD_SPAN 4
`define ISA_CYCLE_NS 125
`define ISA_CYCLE_CLKS ((`ISA_CYCLE_NS + 49) / 50)
`define STD_CYCLES_8 6
`define STD_CYCLES_16 3
`define SHORT_CYCLES_8 3
`define EXTRA_WAIT_CYCLES 1
`endif

// ### logic/card_window_pkg.sv
package card_window_pkg;
   typedef struct packed {
      logic req;
      logic is_io;
      logic [23:0] addr;
   } host_cycle_t;
   typedef struct packed {
      logic claim;
      logic is_io;
      logic [2:0] window;
      logic wide;
      logic [7:0] cycle_clks;
   } card_access_t;
endpackage

// ### logic/card_window_enable_io_control.sv
// Overview of operation
// - Disabled windows never claim host cycles.
// - Reset disables every window, reads zero.
// - Bits 7 and 6 enable I/O windows.
// - Bits 4..0 enable memory windows 4..0.
// - Bit 5 reserved, always reads zero.
// - Wait bit lengthens 16-bit I/O cycles.
// - Short bit makes 8-bit cycles three.
// - Auto-size bit follows card I/O-16 indication.
// - Width bit picks 8 or 16 bits.
// - I/O control register resets to zero.
`timescale 1ns/1ps
`include "card_window_regs.svh"
module card_window_enable_io_control (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   input wire card_window_pkg::host_cycle_t host_cycle_i,
   input wire logic [24*7-1:0] win_start_i,
   input wire logic [24*7-1:0] win_end_i,
   input wire logic card_io_sixteen_indication_i,
   output card_window_pkg::card_access_t access_o,
   output logic [7:0] window_enable_o
);
   logic [7:0] win_en_ff;
   logic [7:0] io_ctrl_ff;
   logic [7:0] nxt_rdata;
   card_window_pkg::card_access_t access_ff;
   card_window_pkg::card_access_t nxt_access;
   logic [6:0] hit;
   logic [6:0] win_on;
   logic sel_en;
   logic sel_ctrl;

   assign sel_en = reg_addr_i == `WIN_EN_OFFSET;
   assign sel_ctrl = reg_addr_i == `IO_CTRL_OFFSET;
   // Index 0..4 memory windows, 5..6 I/O windows 0..1
   assign win_on = {win_en_ff[`IO1_EN_BIT], win_en_ff[`IO0_EN_BIT], win_en_ff[4:0]};

   genvar g;
   generate
      for (g = 0; g < 7; g++) begin : g_hit
         localparam bit IS_IO = g >= 5;
         assign hit[g] = win_on[g] && host_cycle_i.req && (host_cycle_i.is_io == IS_IO)
            && host_cycle_i.addr >= win_start_i[g*24 +: 24]
            && host_cycle_i.addr <= win_end_i[g*24 +: 24];
      end
   endgenerate

   // Unmapped offsets read zero; bit 5 is never stored
   assign nxt_rdata = sel_en ? (win_en_ff & `WIN_EN_WRITE_MASK) :
                      sel_ctrl ? io_ctrl_ff : 8'h00;

   always_comb begin
      logic [3:0] f;
      logic wide;
      f = 4'h0;
      wide = 1'b0;
      nxt_access = '0;
      nxt_access.is_io = host_cycle_i.is_io;
      // Lowest window wins when ranges overlap
      for (int i = 6; i >= 0; i--) begin
         if (hit[i]) begin
            nxt_access.claim = 1'b1;
            nxt_access.window = 3'(i);
         end
      end
      if (nxt_access.claim && nxt_access.window >= 3'h5) begin
         f = (nxt_access.window == 3'h6) ? io_ctrl_ff[7:4] : io_ctrl_ff[3:0];
         wide = f[1] ? card_io_sixteen_indication_i : f[0];
         nxt_access.wide = wide;
         if (wide) begin
            nxt_access.cycle_clks = 8'((`STD_CYCLES_16 + (f[3] ? `EXTRA_WAIT_CYCLES : 0))
               * `ISA_CYCLE_CLKS);
         end else begin
            nxt_access.cycle_clks = 8'((f[2] ? `SHORT_CYCLES_8 : `STD_CYCLES_8)
               * `ISA_CYCLE_CLKS);
         end
      end else if (nxt_access.claim) begin
         nxt_access.wide = 1'b1;
         nxt_access.cycle_clks = 8'(`STD_CYCLES_16 * `ISA_CYCLE_CLKS);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         win_en_ff <= `WIN_EN_RESET;
         io_ctrl_ff <= `IO_CTRL_RESET;
         reg_rdata_o <= 8'h00;
         access_ff <= '0;
      end else begin
         if (reg_wr_i && sel_en) win_en_ff <= reg_wdata_i & `WIN_EN_WRITE_MASK;
         if (reg_wr_i && sel_ctrl) io_ctrl_ff <= reg_wdata_i;
         reg_rdata_o <= nxt_rdata;
         access_ff <= nxt_access;
      end
   end

   assign access_o = access_ff;
   assign window_enable_o = win_en_ff;

   property p_no_claim_disabled;
      @(posedge sys_clk_i) disable iff (rst_i)
      (host_cycle_i.req && hit == 7'h00) |=> !access_o.claim;
   endproperty
   a_no_claim_disabled: assert property (p_no_claim_disabled) else $error("claim on disabled");

   property p_reset_zero;
      @(posedge sys_clk_i) rst_i |=> (win_en_ff == 8'h00 && io_ctrl_ff == 8'h00);
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("reset not zero");

   property p_io1_en;
      @(posedge sys_clk_i) disable iff (rst_i)
      (reg_wr_i && sel_en) |=> window_enable_o[7] == $past(reg_wdata_i[7]);
   endproperty
   a_io1_en: assert property (p_io1_en) else $error("io1 enable not stored");

   property p_mem_en;
      @(posedge sys_clk_i) disable iff (rst_i)
      (reg_wr_i && sel_en) |=> window_enable_o[4:0] == $past(reg_wdata_i[4:0]);
   endproperty
   a_mem_en: assert property (p_mem_en) else $error("memory enables not stored");

   property p_reserved_bit;
      @(posedge sys_clk_i) disable iff (rst_i)
      sel_en |=> !reg_rdata_o[5];
   endproperty
   a_reserved_bit: assert property (p_reserved_bit) else $error("reserved bit set");

   property p_wait16;
      @(posedge sys_clk_i) disable iff (rst_i)
      (hit[5] && hit[4:0] == 5'h00 && io_ctrl_ff[3] && nxt_access.wide)
      |=> access_o.cycle_clks == 8'(4 * `ISA_CYCLE_CLKS);
   endproperty
   a_wait16: assert property (p_wait16) else $error("16-bit wait not applied");

   property p_short8;
      @(posedge sys_clk_i) disable iff (rst_i)
      (access_o.claim && access_o.window == 3'h6 && !access_o.wide && io_ctrl_ff[6]
       && $stable(io_ctrl_ff)) |-> access_o.cycle_clks == 8'(3 * `ISA_CYCLE_CLKS);
   endproperty
   a_short8: assert property (p_short8) else $error("8-bit short cycle wrong");

   property p_auto;
      @(posedge sys_clk_i) disable iff (rst_i)
      (hit[5] && hit[4:0] == 5'h00 && io_ctrl_ff[1])
      |=> access_o.wide == $past(card_io_sixteen_indication_i);
   endproperty
   a_auto: assert property (p_auto) else $error("auto size ignored");

   property p_width;
      @(posedge sys_clk_i) disable iff (rst_i)
      (hit[5] && hit[4:0] == 5'h00 && !io_ctrl_ff[1]) |=> access_o.wide == $past(io_ctrl_ff[0]);
   endproperty
   a_width: assert property (p_width) else $error("width select ignored");

   property p_io0_en;
      @(posedge sys_clk_i) disable iff (rst_i)
      (reg_wr_i && sel_en) |=> window_enable_o[6] == $past(reg_wdata_i[6]);
   endproperty
   a_io0_en: assert property (p_io0_en) else $error("io0 enable not stored");

   property p_ctrl_reset;
      @(posedge sys_clk_i) rst_i |=> io_ctrl_ff == `IO_CTRL_RESET;
   endproperty
   a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not reset");

   property p_ctrl_store;
      @(posedge sys_clk_i) disable iff (rst_i)
      (reg_wr_i && sel_ctrl) |=> io_ctrl_ff == $past(reg_wdata_i);
   endproperty
   a_ctrl_store: assert property (p_ctrl_store) else $error("control not stored");

   property p_claim_range;
      @(posedge sys_clk_i) disable iff (rst_i)
      access_o.claim |-> $past(hit) != 7'h00;
   endproperty
   a_claim_range: assert property (p_claim_range) else $error("claim outside windows");

   property p_window_index;
      @(posedge sys_clk_i) disable iff (rst_i)
      hit[0] |=> (access_o.claim && access_o.window == 3'h0);
   endproperty
   a_window_index: assert property (p_window_index) else $error("wrong window index");

   property p_mem_timing;
      @(posedge sys_clk_i) disable iff (rst_i)
      (hit[4:0] != 5'h00)
      |=> (access_o.wide && access_o.cycle_clks == 8'(`STD_CYCLES_16 * `ISA_CYCLE_CLKS));
   endproperty
   a_mem_timing: assert property (p_mem_timing) else $error("memory timing wrong");

   // Wait bit must not stretch an 8-bit cycle
   property p_wait8;
      @(posedge sys_clk_i) disable iff (rst_i)
      (hit[5] && hit[4:0] == 5'h00 && !nxt_access.wide && !io_ctrl_ff[2])
      |=> access_o.cycle_clks == 8'(`STD_CYCLES_8 * `ISA_CYCLE_CLKS);
   endproperty
   a_wait8: assert property (p_wait8) else $error("8-bit cycle stretched");

   property p_short16;
      @(posedge sys_clk_i) disable iff (rst_i)
      (hit[5] && hit[4:0] == 5'h00 && nxt_access.wide && !io_ctrl_ff[3])
      |=> access_o.cycle_clks == 8'(`STD_CYCLES_16 * `ISA_CYCLE_CLKS);
   endproperty
   a_short16: assert property (p_short16) else $error("16-bit cycle shortened");

   property p_io_off;
      @(posedge sys_clk_i) disable iff (rst_i)
      (host_cycle_i.req && host_cycle_i.is_io && win_en_ff[7:6] == 2'b00) |=> !access_o.claim;
   endproperty
   a_io_off: assert property (p_io_off) else $error("claim on disabled I/O");

   property p_mem_off;
      @(posedge sys_clk_i) disable iff (rst_i)
      (host_cycle_i.req && !host_cycle_i.is_io && win_en_ff[4:0] == 5'h00) |=> !access_o.claim;
   endproperty
   a_mem_off: assert property (p_mem_off) else $error("claim on disabled memory");
endmodule

// ### testbench/card_io_model.sv
`timescale 1ns/1ps
module card_io_model (
   input wire logic wide_port_i,
   output logic card_io_sixteen_indication_o = 1'b0
);
   // The card's port decode answers a little after the address settles
   always @(wide_port_i) card_io_sixteen_indication_o = #5 wide_port_i;
endmodule

// ### testbench/card_window_enable_io_control_test.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module card_window_enable_io_control_test;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [11:0] reg_addr_i = 12'h000;
   logic reg_wr_i = 1'b0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic [7:0] reg_rdata_o;
   logic [7:0] window_enable_o;
   card_window_pkg::host_cycle_t host_cycle_i = '0;
   card_window_pkg::card_access_t access_o;
   logic [167:0] win_start_i;
   logic [167:0] win_end_i;
   logic wide_port = 1'b0;
   logic io16;
   int n_errors = 0;
   int checks_done = 0;
   // Control nibble, card width, expected width and cycle length
   logic [13:0] modes [8] = '{14'h0012, 14'h0509, 14'h250C, 14'h2012, 14'h1009, 14'h1509,
      14'h0B09, 14'h0C12};
   always #25 sys_clk_i = ~sys_clk_i;
   card_window_enable_io_control u_card_window_enable_io_control (.sys_clk_i, .rst_i,
      .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .host_cycle_i, .win_start_i,
      .win_end_i, .card_io_sixteen_indication_i(io16), .access_o, .window_enable_o);
   card_io_model u_card_io_model (.wide_port_i(wide_port), .card_io_sixteen_indication_o(io16));
   task wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge sys_clk_i);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(negedge sys_clk_i);
      reg_wr_i = 1'b0;
   endtask
   task rd(input logic [11:0] a, input logic [7:0] e);
      @(negedge sys_clk_i);
      reg_addr_i = a;
      @(negedge sys_clk_i);
      `CHK(reg_rdata_o, e)
   endtask
   // Claim-free answers leave the other fields open, so only claim is compared
   task acc(input logic io, input int w, input logic [13:0] e);
      @(negedge sys_clk_i);
      host_cycle_i = {1'b1, io, 24'(w * 256 + 128)};
      @(negedge sys_clk_i);
      host_cycle_i.req = 1'b0;
      if (e[13]) `CHK(access_o, e) else `CHK(access_o.claim, 1'b0)
   endtask
   task conclude;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      for (int k = 0; k < 7; k++) begin
         win_start_i[24*k +: 24] = 24'(k * 256);
         win_end_i[24*k +: 24] = 24'(k * 256 + 255);
      end
      repeat (6) @(negedge sys_clk_i);
      rst_i = 1'b0;
      rd(12'h806, 8'h00);
      rd(12'h807, 8'h00);
      acc(1'b1, 5, 14'h0000);
      wr(12'h806, 8'hFF);
      rd(12'h806, 8'hDF);
      `CHK(window_enable_o, 8'hDF)
      acc(1'b0, 255, 14'h0000);
      wr(12'h808, 8'hFF);
      rd(12'h808, 8'h00);
      wr(12'h807, 8'hA5);
      rd(12'h807, 8'hA5);
      wr(12'h807, 8'h00);
      for (int b = 0; b < 8; b++) if (b != 5) begin
         wr(12'h806, 8'(1 << b));
         acc(b > 5, b > 5 ? b - 1 : b, b > 5 ? {2'b11, 3'(b - 1), 9'h012} : {2'b10, 3'(b), 9'h109});
         acc(b <= 5, b > 5 ? 0 : 5, 14'h0000);
      end
      wr(12'h806, 8'hC0);
      for (int w = 5; w < 7; w++) for (int m = 0; m < 8; m++) begin
         wr(12'h807, 8'({4'h0, modes[m][13:10]} << (4 * (w - 5))));
         wide_port = modes[m][9];
         acc(1'b1, w, {2'b11, 3'(w), modes[m][8:0]});
      end
      @(negedge sys_clk_i);
      rst_i = 1'b1;
      @(negedge sys_clk_i);
      rst_i = 1'b0;
      rd(12'h806, 8'h00);
      rd(12'h807, 8'h00);
      acc(1'b1, 6, 14'h0000);
      conclude();
   end
endmodule
